// File: rtl/osd_map.vh
// constants, register map and timing counts of the shadow / line double / glyph fetch stage
// How it works
// - shadow only on rom and 1-bit redefinable glyphs while enable is one
// - one enable bit in the display config word switches shadow on or off
// - shadow pixels use a 6-bit colour index, any entry 0 to 63
// - direction bit zero means east shadow, one means west shadow
// - shadow looks only at pixels of the current character matrix
// - no shadow pixel crosses into the neighbouring character matrix
// - progressive scan outputs each display line twice
// - line repeat only inside the character display area
// - progressive control bit one enables line repeat, zero disables
// - redefinable glyphs read from on-chip ram at 1, 2 or 4 bits per pixel
// - each glyph starts on a fresh byte, odd heights leave last nibble free in 1-bit glyphs
// - 1-bit glyphs pack continuously across lines, leftmost pixel in bit 7 on even lines, bit 3 on odd lines
// - 3-bit height code, 000 is 9 lines, each step adds one line
// - every character matrix is exactly 12 pixels wide
`ifndef OSD_MAP_VH
`define OSD_MAP_VH
`define OSD_CFG_ADDR        12'h000
`define OSD_BASE1_ADDR      12'h004
`define OSD_BASE2_ADDR      12'h008
`define OSD_BASE4_ADDR      12'h00c
`define OSD_STAT_ADDR       12'h010
`define OSD_SHADOW_ENABLE_BIT        0
`define OSD_SHDIR_BIT       1
`define OSD_PROG_BIT        2
`define OSD_HGT_LSB         4
`define OSD_SHADOW_COLOUR_INDEX_LSB       8
`define OSD_CFG_RESET       32'h0000_0000
`define OSD_MATRIX_W        12
`define OSD_MIN_LINES       9
`define OSD_FMT_ROM         2'h0
`define OSD_FMT_ONE         2'h1
`define OSD_FMT_TWO         2'h2
`define OSD_FMT_FOUR        2'h3
`endif

// File: rtl/osd_line_fetch.v
// fetches one 12-pixel glyph line from on-chip ram and unpacks it
`timescale 1ns/100ps
`include "osd_map.vh"
module osd_line_fetch #(
    parameter AW = 16
) (
    input  wire          pclk,
    input  wire          presetn,
    input  wire          start,
    input  wire [1:0]    fmt,
    input  wire [AW-1:0] base,
    input  wire [7:0]    glyph,
    input  wire [3:0]    line,
    input  wire [2:0]    hgt_code,
    output reg  [AW-1:0] ram_addr,
    output reg           ram_rd,
    input  wire [7:0]    ram_data,
    output reg  [47:0]   pix,
    output reg           done
);
    reg  [4:0]    nlines;
    reg  [10:0]   bits_per_glyph;
    reg  [10:0]   bytes_per_glyph;
    reg  [15:0]   bit_off;
    reg  [AW-1:0] first_byte;
    reg  [3:0]    bitpos;
    reg  [2:0]    bpp;
    reg  [3:0]    cnt;
    reg  [3:0]    nbytes;
    reg           busy;
    reg           wait_data;
    reg  [95:0]   sh;
    reg           last;
    reg  [3:0]    bitpos_q;
    always @* begin
        nlines = {2'b00, hgt_code} + 5'd`OSD_MIN_LINES;
        case (fmt)
            `OSD_FMT_TWO:  bpp = 3'd2;
            `OSD_FMT_FOUR: bpp = 3'd4;
            default:       bpp = 3'd1;
        endcase
        // line is 12 pixels times depth
        bits_per_glyph  = nlines * 11'd`OSD_MATRIX_W * bpp;
        bytes_per_glyph = (bits_per_glyph + 11'd7) >> 3;
        bit_off         = {12'h000, line} * 16'd`OSD_MATRIX_W * bpp;
        first_byte      = base + glyph * {{(AW-11){1'b0}}, bytes_per_glyph} + bit_off[15:3];
        bitpos          = {1'b0, bit_off[2:0]};
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ram_addr  <= {AW{1'b0}};
            ram_rd    <= 1'b0;
            pix       <= 48'h0;
            done      <= 1'b0;
            busy      <= 1'b0;
            wait_data <= 1'b0;
            cnt       <= 4'h0;
            nbytes    <= 4'h0;
            sh        <= 96'h0;
            last      <= 1'b0;
            bitpos_q  <= 4'h0;
        end else begin
            done   <= 1'b0;
            ram_rd <= 1'b0;
            last   <= 1'b0;
            if (start && !busy) begin
                busy     <= 1'b1;
                ram_addr <= first_byte;
                ram_rd   <= 1'b1;
                cnt      <= 4'h0;
                nbytes   <= (bpp == 3'd4) ? 4'd7 : (bpp == 3'd2) ? 4'd4 : 4'd3;
                sh       <= 96'h0;
                bitpos_q <= bitpos;
                wait_data <= 1'b1;
            end else if (busy && wait_data) begin
                sh <= {sh[87:0], ram_data}; // 1-bit: leftmost pixel is bit 7 of the first byte on even lines, bit 3 on odd lines; 2/4-bit: leftmost pixel in the low bits of the last byte
                if (cnt + 4'd1 == nbytes) begin
                    busy      <= 1'b0;
                    wait_data <= 1'b0;
                    last      <= 1'b1;
                end else begin
                    cnt      <= cnt + 4'd1;
                    ram_addr <= ram_addr + {{(AW-1){1'b0}}, 1'b1};
                    ram_rd   <= 1'b1;
                end
            end
            // the first byte shifted in is the stale bus value, so only the
            // newest bytes are used; pix and done rise together for the consumer
            if (last) begin
                done <= 1'b1;
                case (nbytes)
                    4'd7:    pix <= sh[47:0];
                    4'd4:    pix <= {24'h000000, sh[23:0]};
                    default: pix <= {36'h0, bitpos_q[2] ? sh[11:0] : sh[15:4]};
                endcase
            end
        end
    end
endmodule

// File: rtl/osd_shadow_line_double.v
// pixel stage: shadow, line doubling, glyph fetch, apb configuration
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "osd_map.vh"
module osd_shadow_line_double #(
    parameter AW = 16
) (
    input  wire          pclk,
    input  wire          presetn,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [11:0]   paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output wire          pready,
    output wire          pslverr,
    input  wire          char_start,
    input  wire [1:0]    char_fmt,
    input  wire [7:0]    char_code,
    input  wire [3:0]    char_line,
    input  wire [11:0]   rom_pixels,
    input  wire [5:0]    fg_index,
    input  wire [5:0]    bg_index,
    input  wire          in_area,
    input  wire          line_end,
    output wire [AW-1:0] ram_addr,
    output wire          ram_rd,
    input  wire [7:0]    ram_data,
    output reg  [5:0]    pix_index,
    output reg           pix_valid,
    output reg           repeat_line
);
    reg  [31:0]   cfg;
    reg  [AW-1:0] base1;
    reg  [AW-1:0] base2;
    reg  [AW-1:0] base4;
    reg  [AW-1:0] base_sel;
    reg  [11:0]   fg_mask;
    reg  [11:0]   shadow_mask;
    reg  [47:0]   colour;
    reg  [1:0]    fmt_q;
    reg  [3:0]    px;
    reg           shading;
    reg           fetch_busy;
    reg           run;
    wire [47:0]   fetched;
    wire          fetch_done;
    wire          shadow_enable  = cfg[`OSD_SHADOW_ENABLE_BIT];
    wire          shdir = cfg[`OSD_SHDIR_BIT];
    wire          prog  = cfg[`OSD_PROG_BIT];
    wire [2:0]    hgt   = cfg[`OSD_HGT_LSB+2:`OSD_HGT_LSB];
    wire [5:0]    shadow_colour_index = cfg[`OSD_SHADOW_COLOUR_INDEX_LSB+5:`OSD_SHADOW_COLOUR_INDEX_LSB];
    wire          wr    = psel && penable && pwrite;
    wire          addr_ok = (paddr == `OSD_CFG_ADDR) || (paddr == `OSD_BASE1_ADDR) ||
                            (paddr == `OSD_BASE2_ADDR) || (paddr == `OSD_BASE4_ADDR) ||
                            (paddr == `OSD_STAT_ADDR);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg   <= `OSD_CFG_RESET;
            base1 <= {AW{1'b0}};
            base2 <= {AW{1'b0}};
            base4 <= {AW{1'b0}};
        end else if (wr) begin
            case (paddr)
                `OSD_CFG_ADDR:   cfg   <= pwdata & 32'h0000_3f77;
                `OSD_BASE1_ADDR: base1 <= pwdata[AW-1:0];
                `OSD_BASE2_ADDR: base2 <= pwdata[AW-1:0];
                `OSD_BASE4_ADDR: base4 <= pwdata[AW-1:0];
                default:         cfg   <= cfg;
            endcase
        end
    end
    always @* begin
        case (paddr)
            `OSD_CFG_ADDR:   prdata = cfg;
            `OSD_BASE1_ADDR: prdata = {{(32-AW){1'b0}}, base1};
            `OSD_BASE2_ADDR: prdata = {{(32-AW){1'b0}}, base2};
            `OSD_BASE4_ADDR: prdata = {{(32-AW){1'b0}}, base4};
            `OSD_STAT_ADDR:  prdata = {28'h0, fetch_busy, repeat_line, pix_valid, shading};
            default:         prdata = 32'h0;
        endcase
    end
    always @* begin
        case (char_fmt)
            `OSD_FMT_TWO:  base_sel = base2;
            `OSD_FMT_FOUR: base_sel = base4;
            default:       base_sel = base1;
        endcase
    end
    osd_line_fetch #(
        .AW(AW)
    ) u_fetch (
        .pclk     (pclk),
        .presetn  (presetn),
        .start    (char_start && char_fmt != `OSD_FMT_ROM),
        .fmt      (char_fmt),
        .base     (base_sel),
        .glyph    (char_code),
        .line     (char_line),
        .hgt_code (hgt),
        .ram_addr (ram_addr),
        .ram_rd   (ram_rd),
        .ram_data (ram_data),
        .pix      (fetched),
        .done     (fetch_done)
    );
    // shadow masks are built per matrix, so shifted bits fall off the 12-pixel edge
    function [11:0] shade;
        input [11:0] fg;
        input        west;
        begin
            if (west)
                shade = (fg << 1) & ~fg;
            else
                shade = (fg >> 1) & ~fg;
        end
    endfunction
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fg_mask     <= 12'h000;
            shadow_mask <= 12'h000;
            colour      <= 48'h0;
            fmt_q       <= `OSD_FMT_ROM;
            px          <= 4'h0;
            pix_valid   <= 1'b0;
            pix_index   <= 6'h00;
            fetch_busy  <= 1'b0;
            shading     <= 1'b0;
            run         <= 1'b0;
        end else begin
            // pix_valid follows run by one cycle so it qualifies pix_index exactly
            pix_valid <= run;
            if (char_start && char_fmt == `OSD_FMT_ROM) begin
                fg_mask     <= rom_pixels;
                shadow_mask <= shadow_enable ? shade(rom_pixels, shdir) : 12'h000;
                fmt_q       <= `OSD_FMT_ROM;
                px          <= 4'h0;
                run         <= 1'b1;
                shading     <= shadow_enable;
            end else if (char_start) begin
                fetch_busy <= 1'b1;
                fmt_q      <= char_fmt;
                run        <= 1'b0;
            end else if (fetch_done) begin
                fetch_busy  <= 1'b0;
                colour      <= fetched;
                fg_mask     <= fetched[11:0];
                shadow_mask <= (shadow_enable && fmt_q == `OSD_FMT_ONE) ?
                               shade(fetched[11:0], shdir) : 12'h000;
                shading     <= shadow_enable && fmt_q == `OSD_FMT_ONE;
                px          <= 4'h0;
                run         <= 1'b1;
            end else if (run) begin
                if (px == 4'd`OSD_MATRIX_W - 4'd1)
                    run <= 1'b0;
                else
                    px <= px + 4'd1;
            end
            if (run) begin
                case (fmt_q)
                    `OSD_FMT_TWO:  pix_index <= {fg_index[5:2], colour[2*px+:2]};
                    `OSD_FMT_FOUR: pix_index <= {fg_index[5:4], colour[4*px+:4]};
                    default:
                        if (fg_mask[4'd11 - px])
                            pix_index <= fg_index;
                        else if (shadow_mask[4'd11 - px])
                            pix_index <= shadow_colour_index;
                        else
                            pix_index <= bg_index;
                endcase
            end
        end
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            repeat_line <= 1'b0;
        else if (line_end)
            repeat_line <= prog && in_area && !repeat_line;
    end
endmodule

// File: verification/osd_ram_model.sv
// behavioural on-chip glyph ram, answers one cycle after a read strobe
`timescale 1ns/100ps
module osd_ram_model (
    input  wire logic        pclk,
    input  wire logic        ram_rd,
    input  wire logic [15:0] ram_addr,
    output logic      [7:0]  ram_data
);
    initial ram_data = 8'h00;
    // between reads the bus shows the inverse, so stale data never looks valid
    always @(posedge pclk) begin
        if (ram_rd)
            ram_data <= ram_addr[7:0] ^ 8'h5a;
        else
            ram_data <= ~ram_data;
    end
endmodule

// File: verification/osd_shadow_monitor.sv
// port assertions for the pixel stage
`timescale 1ns/100ps
module osd_shadow_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    input wire logic        char_start,
    input wire logic [1:0]  char_fmt,
    input wire logic [5:0]  fg_index,
    input wire logic [5:0]  bg_index,
    input wire logic        in_area,
    input wire logic        line_end,
    input wire logic [5:0]  pix_index,
    input wire logic        pix_valid,
    input wire logic        repeat_line
);
    // copy of the config word, follows every accepted write to offset 0
    logic [31:0] cfg;
    logic        mono;
    logic        plain;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= 32'h0;
            mono <= 1'b0;
        end else begin
            if (psel && penable && pwrite && paddr == 12'h000)
                cfg <= pwdata;
            if (char_start && !pix_valid)
                mono <= !char_fmt[1];
        end
    end
    assign plain = pix_index == fg_index || pix_index == bg_index;
    sequence run12;
        pix_valid [*8] ##1 pix_valid [*4] ##1 !pix_valid;
    endsequence
    pix_run_a: assert property ($rose(pix_valid) |-> run12)
        else $error("pixel run length wrong");
    shadow_off_a: assert property (pix_valid && mono && !cfg[0] |-> plain)
        else $error("shadow pixel while disabled");
    shadow_col_a: assert property (pix_valid && mono && !plain |->
        cfg[0] && pix_index == cfg[13:8]) else $error("shadow colour wrong");
    east_edge_a: assert property ($rose(pix_valid) && mono && !cfg[1] |-> plain)
        else $error("shadow entered from left neighbour");
    west_edge_a: assert property ($fell(pix_valid) && mono && cfg[1] |-> $past(plain))
        else $error("shadow entered from right neighbour");
    rep_on_a: assert property (line_end && in_area && cfg[2] && !repeat_line |=>
        repeat_line) else $error("line not repeated");
    rep_off_a: assert property (line_end && in_area && cfg[2] && repeat_line |=>
        !repeat_line) else $error("line repeated twice");
    area_a: assert property (line_end && !in_area |=> !repeat_line)
        else $error("repeat outside area");
    prog_off_a: assert property (line_end && !cfg[2] |=> !repeat_line)
        else $error("repeat while progressive off");
    unmapped_a: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
        else $error("unmapped access without error");
endmodule
bind osd_shadow_line_double osd_shadow_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pslverr, .char_start, .char_fmt, .fg_index, .bg_index, .in_area,
    .line_end, .pix_index, .pix_valid, .repeat_line);

// File: verification/osd_shadow_line_double_bench.sv
// self-checking bench for the pixel stage
`timescale 1ns/100ps
module osd_shadow_line_double_bench;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000, rom_pixels = 12'h901, p;
    logic [31:0] pwdata = 32'h0, prdata, rq;
    logic        pready, pslverr, re, ram_rd, pix_valid, repeat_line;
    logic        char_start = 1'b0, in_area = 1'b0, line_end = 1'b0;
    logic [1:0]  char_fmt = 2'h0;
    logic [7:0]  char_code = 8'h02, ram_data;
    logic [3:0]  char_line = 4'h1;
    logic [5:0]  fg_index = 6'h05, bg_index = 6'h0a, pix_index, sc;
    logic [5:0]  ex [12];
    logic [15:0] ram_addr;
    int          miscompares = 0, cmp_count = 0, m, i;
    osd_shadow_line_double #(.AW(16)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .char_start, .char_fmt, .char_code, .char_line,
        .rom_pixels, .fg_index, .bg_index, .in_area, .line_end, .ram_addr, .ram_rd, .ram_data,
        .pix_index, .pix_valid, .repeat_line);
    osd_ram_model ram (.pclk, .ram_rd, .ram_addr, .ram_data);
    always #4 pclk = ~pclk;
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 50) begin
            miscompares++;
            stop_test;
        end
    endtask
    // leftmost pixel is bit 11 of the pattern; a glyph's size is rounded up to whole bytes
    function automatic logic [11:0] glyph(int h, int l);
        int b;
        logic [7:0] d;
        for (int k = 0; k < 12; k++) begin
            b = l * 12 + k;
            d = 8'(256 + 2 * ((12 * h + 7) / 8) + b / 8) ^ 8'h5a;
            glyph[11 - k] = d[7 - b % 8];
        end
    endfunction
    function automatic logic [5:0] px(int i, logic s, logic w);
        if (p[11 - i]) return fg_index;
        if (s && !w && i > 0 && p[12 - i]) return sc;
        if (s && w && i < 11 && p[10 - i]) return sc;
        return bg_index;
    endfunction
    task automatic run_char;
        int n;
        @(posedge pclk);
        char_start <= 1'b1;
        @(posedge pclk);
        char_start <= 1'b0;
        for (n = 0; n < 100 && pix_valid !== 1'b1; n++) @(posedge pclk);
        if (n == 100) begin
            miscompares++;
            stop_test;
        end
        for (n = 0; n < 12; n++) begin
            chk("pixel", 32'(ex[n]), 32'(pix_index));
            @(posedge pclk);
        end
        chk("run end", 32'h0, 32'(pix_valid));
    endtask
    task automatic pulse(logic a);
        @(posedge pclk);
        in_area <= a;
        line_end <= 1'b1;
        @(posedge pclk);
        line_end <= 1'b0;
        @(posedge pclk);
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk("cfg reset", 32'h0, rq);
        apb(1'b0, 12'h014, 32'h0);
        chk("unmapped err", 32'h1, 32'(re));
        apb(1'b1, 12'h004, 32'h100);
        apb(1'b0, 12'h004, 32'h0);
        chk("glyph base", 32'h100, rq);
        $display("register test done");
        // rom glyphs then one-bit glyphs, all shadow modes, colours 63 and 0
        for (m = 0; m < 8; m++) begin
            sc = m[2] ? 6'h00 : 6'h3f;
            apb(1'b1, 12'h000, {18'h0, sc, 1'b0, 3'(m), 2'b00, m[1], m[0]});
            apb(1'b0, 12'h000, 32'h0);
            chk("cfg", {18'h0, sc, 1'b0, 3'(m), 2'b00, m[1], m[0]}, rq);
            char_fmt <= {1'b0, m[2]};
            char_line <= 4'(m + 1);
            p = m[2] ? glyph(9 + m, m + 1) : 12'h901;
            for (i = 0; i < 12; i++) ex[i] = px(i, m[0], m[1]);
            run_char();
        end
        $display("shadow and glyph test done");
        apb(1'b1, 12'h000, 32'h4);
        for (m = 0; m < 5; m++) begin
            pulse(m[0] ^ m[1] ^ 1'b1 | m == 3);
            chk("repeat", 32'((5'b01001 >> m) & 1), 32'(repeat_line));
        end
        pulse(1'b1);
        chk("repeat again", 32'h1, 32'(repeat_line));
        apb(1'b1, 12'h000, 32'h0);
        pulse(1'b1);
        chk("repeat off", 32'h0, 32'(repeat_line));
        $display("progressive test done");
        stop_test;
    end
endmodule
